// file: rtl/branch_call_increment_op_exec.sv
// Purpose: executes enable-irq, far branch, far call, computed branch,
//          increment and software interrupt operations
// Assumes: the core supplies pc, accumulator, table high pointer and the
//          addressed register value together with the request
// Notes: effect strobes are one-cycle pulses; ready low while a multi-cycle op runs, high again in its done cycle
// Notes on behaviour
// - enable-irq op sets global enable, one cycle
// - far branch loads 12-bit target, two cycles
// - far call pushes pc+1, loads target, two cycles
// - computed branch loads pointer bits and accumulator
// - increment register, dest by bit, zero flag
// - software irq pushes, then vectors to 001, three cycles
`timescale 1ns/100ps

module branch_call_increment_op_exec (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // request from the decoder
    input wire logic reqValid,
    input wire branch_exec_pkg::req_t req,
    output logic reqReady,
    // effects on the core
    output branch_exec_pkg::effects_t fx,
    output logic globalIrqEnable
);

    // =========================================================
    // state
    branch_exec_pkg::state_t st_q;
    branch_exec_pkg::state_t st_d;
    logic take;
    logic [branch_exec_pkg::DATA_W-1:0] incSum;
    logic [branch_exec_pkg::PC_W-1:0] returnPc;

    assign take = reqValid && st_q.ready;
    assign incSum = req.regValue + branch_exec_pkg::DATA_STEP;
    assign returnPc = req.pc + branch_exec_pkg::PC_STEP;

    // =========================================================
    // next state
    always_comb begin
        st_d = st_q;
        st_d.fx = '0;
        unique case (st_q.phase)
            branch_exec_pkg::IDLE: begin
                if (take) begin
                    st_d.left = 2'h0;
                    unique case (req.op)
                        branch_exec_pkg::ENABLE_IRQ_OP: begin
                            st_d.globalIrqEnable = 1'b1;
                            st_d.left = branch_exec_pkg::CYC_ENABLE_IRQ;
                        end
                        branch_exec_pkg::FAR_BRANCH_OP: begin
                            st_d.fx.pcLoad = 1'b1;
                            st_d.fx.pcValue = req.target;
                            st_d.left = branch_exec_pkg::CYC_FAR_BRANCH;
                        end
                        branch_exec_pkg::FAR_CALL_OP: begin
                            st_d.fx.stackPush = 1'b1;
                            st_d.fx.stackValue = returnPc;
                            st_d.fx.pcLoad = 1'b1;
                            st_d.fx.pcValue = req.target;
                            st_d.left = branch_exec_pkg::CYC_FAR_CALL;
                        end
                        branch_exec_pkg::COMPUTED_BRANCH_OP: begin
                            st_d.fx.pcLoad = 1'b1;
                            st_d.fx.pcValue = {req.pc[11], req.tableHighPointer[2:0],
                                               req.accumulator};
                            st_d.left = branch_exec_pkg::CYC_COMPUTED_BRANCH;
                        end
                        branch_exec_pkg::INCREMENT_OP: begin
                            st_d.fx.regWe = req.destReg;
                            st_d.fx.accumulatorWe = !req.destReg;
                            st_d.fx.regAddr = req.regAddr;
                            st_d.fx.regValue = incSum;
                            st_d.fx.accumulatorValue = incSum;
                            st_d.fx.zeroWe = 1'b1;
                            st_d.fx.zeroValue = (incSum == '0);
                            st_d.left = branch_exec_pkg::CYC_INCREMENT;
                        end
                        branch_exec_pkg::SOFT_IRQ_OP: begin
                            st_d.fx.stackPush = 1'b1;
                            st_d.fx.stackValue = returnPc;
                            st_d.vectorPending = 1'b1;
                            st_d.vectorPc = {req.pc[11], branch_exec_pkg::SOFT_IRQ_VECTOR};
                            st_d.left = branch_exec_pkg::CYC_SOFT_IRQ;
                        end
                        default: begin
                            st_d.left = 2'h1;
                        end
                    endcase
                    if (st_d.left == 2'h1) begin
                        st_d.fx.done = 1'b1;
                        st_d.left = 2'h0;
                    end else begin
                        st_d.left = st_d.left - 2'h1;
                        st_d.phase = branch_exec_pkg::BUSY;
                        st_d.ready = 1'b0;
                    end
                end
            end
            branch_exec_pkg::BUSY: begin
                if (st_q.vectorPending) begin
                    st_d.fx.pcLoad = 1'b1;
                    st_d.fx.pcValue = st_q.vectorPc;
                    st_d.vectorPending = 1'b0;
                end
                if (st_q.left == 2'h1) begin
                    st_d.phase = branch_exec_pkg::IDLE;
                    st_d.ready = 1'b1;
                    st_d.fx.done = 1'b1;
                    st_d.left = 2'h0;
                end else begin
                    st_d.left = st_q.left - 2'h1;
                end
            end
        endcase
    end

    // =========================================================
    // registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= branch_exec_pkg::ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign reqReady = st_q.ready;
    assign fx = st_q.fx;
    assign globalIrqEnable = st_q.globalIrqEnable;

    // =========================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_ENABLE_IRQ: assert property (
        take && req.op == branch_exec_pkg::ENABLE_IRQ_OP |=>
            globalIrqEnable && fx.done && !fx.zeroWe && reqReady)
        else $error("enable irq op did not set enable in one cycle");

    AST_FAR_BRANCH: assert property (
        take && req.op == branch_exec_pkg::FAR_BRANCH_OP |=>
            fx.pcLoad && fx.pcValue == $past(req.target) && !fx.stackPush && !reqReady
            ##1 fx.done && reqReady)
        else $error("far branch target or timing wrong");

    AST_FAR_CALL: assert property (
        take && req.op == branch_exec_pkg::FAR_CALL_OP |=>
            fx.stackPush && fx.stackValue == $past(req.pc) + 12'h001 && fx.pcLoad
            && fx.pcValue == $past(req.target) ##1 fx.done && !fx.pcLoad)
        else $error("far call push or target wrong");

    AST_COMPUTED_BRANCH: assert property (
        take && req.op == branch_exec_pkg::COMPUTED_BRANCH_OP |=>
            fx.pcLoad && fx.pcValue[10:0] == {$past(req.tableHighPointer[2:0]),
            $past(req.accumulator)} ##1 fx.done)
        else $error("computed branch address wrong");

    AST_INCREMENT_DEST: assert property (
        take && req.op == branch_exec_pkg::INCREMENT_OP |=>
            fx.regWe == $past(req.destReg) && fx.accumulatorWe == !$past(req.destReg)
            && fx.regValue == $past(req.regValue) + 8'h01 && fx.done)
        else $error("increment destination or value wrong");

    AST_INCREMENT_ZERO: assert property (
        take && req.op == branch_exec_pkg::INCREMENT_OP |=>
            fx.zeroWe && fx.zeroValue == ($past(req.regValue) == 8'hFF))
        else $error("increment zero flag wrong");

    AST_SOFT_IRQ: assert property (
        take && req.op == branch_exec_pkg::SOFT_IRQ_OP |=>
            fx.stackPush && !fx.pcLoad && fx.stackValue == $past(req.pc) + 12'h001
            ##1 fx.pcLoad && !fx.stackPush && fx.pcValue[10:0] == 11'h001
            ##1 fx.done && reqReady)
        else $error("software irq order or vector wrong");

    AST_FLAGS_KEPT: assert property (
        fx.zeroWe |-> $past(take && req.op == branch_exec_pkg::INCREMENT_OP))
        else $error("zero flag written by non increment op");

    AST_ENABLE_STICKY: assert property (
        globalIrqEnable |=> globalIrqEnable)
        else $error("global enable dropped");

    AST_ENABLE_SOURCE: assert property (
        $rose(globalIrqEnable) |-> $past(take && req.op == branch_exec_pkg::ENABLE_IRQ_OP))
        else $error("global enable set without enable op");

    AST_BUSY_REFUSES: assert property (
        !reqReady |=> !fx.stackPush && !fx.zeroWe && !fx.accumulatorWe && !fx.regWe)
        else $error("request taken while busy");

    AST_BUSY_BOUNDED: assert property (
        !reqReady |-> ##[1:2] reqReady)
        else $error("busy longer than three cycle op");

    AST_BRANCH_NO_DATA: assert property (
        take && (req.op == branch_exec_pkg::FAR_CALL_OP || req.op == branch_exec_pkg::FAR_BRANCH_OP)
            |=> !fx.accumulatorWe && !fx.regWe && !fx.zeroWe)
        else $error("branch or call wrote data or flags");

    AST_ONE_DEST: assert property (
        fx.zeroWe |-> fx.regWe != fx.accumulatorWe)
        else $error("increment wrote not exactly one destination");

    AST_COMPUTED_TOP: assert property (
        take && req.op == branch_exec_pkg::COMPUTED_BRANCH_OP |=> fx.pcValue[11] == $past(req.pc[11]))
        else $error("computed branch changed pc top bit");

    AST_SOFT_IRQ_TOP: assert property (
        take && req.op == branch_exec_pkg::SOFT_IRQ_OP |=> ##1 fx.pcValue[11] == $past(req.pc[11], 2))
        else $error("software irq changed pc top bit");

    COV_SOFT_IRQ: cover property (take && req.op == branch_exec_pkg::SOFT_IRQ_OP ##3 fx.done);
    COV_FAR_CALL: cover property (take && req.op == branch_exec_pkg::FAR_CALL_OP ##2 fx.done);
    COV_INC_ZERO: cover property (fx.zeroWe && fx.zeroValue && fx.regWe);
    COV_BACK_TO_BACK: cover property (fx.done && take);
    COV_REFUSED_HELD: cover property (reqValid && !reqReady ##1 reqValid && reqReady);

endmodule

// file: rtl/branch_exec_pkg.sv
// Purpose: types and constants for the branch, call and increment execution unit
// Assumes: 12-bit program counter, 8-bit data path, 7-bit register address
// Notes: cycle counts are whole instruction cycles of the core clock
package branch_exec_pkg;

    // =========================================================
    // widths and constants
    localparam int PC_W = 12;
    localparam int DATA_W = 8;
    localparam int RADDR_W = 7;
    localparam logic [1:0] CYC_ENABLE_IRQ = 2'h1;
    localparam logic [1:0] CYC_FAR_BRANCH = 2'h2;
    localparam logic [1:0] CYC_FAR_CALL = 2'h2;
    localparam logic [1:0] CYC_COMPUTED_BRANCH = 2'h2;
    localparam logic [1:0] CYC_INCREMENT = 2'h1;
    localparam logic [1:0] CYC_SOFT_IRQ = 2'h3;
    localparam logic [10:0] SOFT_IRQ_VECTOR = 11'h001;
    localparam logic IRQ_ENABLE_RESET = 1'h0;
    localparam logic [PC_W-1:0] PC_STEP = 12'h001;
    localparam logic [DATA_W-1:0] DATA_STEP = 8'h01;

    // =========================================================
    // operations and states
    typedef enum logic [2:0] {
        ENABLE_IRQ_OP,
        FAR_BRANCH_OP,
        FAR_CALL_OP,
        COMPUTED_BRANCH_OP,
        INCREMENT_OP,
        SOFT_IRQ_OP
    } op_t;

    typedef enum logic {
        IDLE,
        BUSY
    } phase_t;

    // =========================================================
    // carriers
    typedef struct packed {
        op_t op;
        logic [PC_W-1:0] target;
        logic [RADDR_W-1:0] regAddr;
        logic destReg;
        logic [DATA_W-1:0] regValue;
        logic [PC_W-1:0] pc;
        logic [DATA_W-1:0] accumulator;
        logic [DATA_W-1:0] tableHighPointer;
    } req_t;

    typedef struct packed {
        logic pcLoad;
        logic [PC_W-1:0] pcValue;
        logic stackPush;
        logic [PC_W-1:0] stackValue;
        logic accumulatorWe;
        logic [DATA_W-1:0] accumulatorValue;
        logic regWe;
        logic [RADDR_W-1:0] regAddr;
        logic [DATA_W-1:0] regValue;
        logic zeroWe;
        logic zeroValue;
        logic done;
    } effects_t;

    typedef struct packed {
        phase_t phase;
        logic [1:0] left;
        logic vectorPending;
        logic [PC_W-1:0] vectorPc;
        logic ready;
        logic globalIrqEnable;
        effects_t fx;
    } state_t;

    localparam state_t ST_RESET = '{phase: IDLE, left: 2'h0, vectorPending: 1'b0,
        vectorPc: 12'h000, ready: 1'b1, globalIrqEnable: IRQ_ENABLE_RESET, fx: '0};

endpackage

// file: verif/branch_call_increment_op_exec_test.sv
// Purpose: self-checking bench for the branch, call and increment unit
// Assumes: effects pulse in cycle 1 (soft irq vector load in cycle 2), done in the last cycle of each op
// Notes: table rows first, then back-to-back, held request, mid-run reset and a soft irq run after reset
`timescale 1ns/100ps

module branch_call_increment_op_exec_test;
    // =========================================================
    // signals
    typedef struct packed {
        branch_exec_pkg::req_t r;
        branch_exec_pkg::effects_t e;
        logic [1:0] n;
    } row_t;
    logic clk;
    logic reset_n;
    logic reqValid;
    logic reqReady;
    logic globalIrqEnable;
    branch_exec_pkg::req_t req;
    branch_exec_pkg::effects_t fx;
    int errors = 0;
    int cmp_count = 0;
    row_t rows [8];

    branch_call_increment_op_exec uut (
        .clk(clk),
        .reset_n(reset_n),
        .reqValid(reqValid),
        .req(req),
        .reqReady(reqReady),
        .fx(fx),
        .globalIrqEnable(globalIrqEnable)
    );

    // =========================================================
    // helpers
    function automatic branch_exec_pkg::req_t mk(branch_exec_pkg::op_t op, logic [11:0] tg,
            logic [6:0] ra, logic d, logic [7:0] rv, logic [11:0] pc, logic [7:0] ac,
            logic [7:0] th);
        return '{op, tg, ra, d, rv, pc, ac, th};
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // one op from take to done, checking every cycle
    task automatic run(input row_t w);
        int k;
        branch_exec_pkg::effects_t x;
        @(posedge clk);
        #1;
        reqValid = 1'h1;
        req = w.r;
        @(posedge clk);
        #1;
        reqValid = 1'h0;
        check(fx, w.e);
        for (k = 1; k <= w.n; k++) begin
            if (k > 1) begin
                @(posedge clk);
                #1;
                x = '0;
                x.done = (k == w.n);
                if (w.r.op == branch_exec_pkg::SOFT_IRQ_OP && k == 2) begin
                    x.pcLoad = 1'h1;
                    x.pcValue = {w.r.pc[11], 11'h001};
                end
                check(fx, x);
            end
            check(reqReady, k == w.n);
        end
    endtask

    // =========================================================
    // clock and watchdog
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end

    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        summarize();
    end

    // =========================================================
    // sequence
    initial begin
        reset_n = 1'h0;
        reqValid = 1'h0;
        req = '0;
        rows[0] = '{mk(branch_exec_pkg::ENABLE_IRQ_OP, 12'h0, 7'h0, 1'h0, 8'h0, 12'h0, 8'h0,
            8'h0), branch_exec_pkg::effects_t'{done:1'h1, default:'0}, 2'h1};
        rows[1] = '{mk(branch_exec_pkg::FAR_BRANCH_OP, 12'hFFF, 7'h0, 1'h0, 8'h0, 12'h0A0, 8'h0,
            8'h0), branch_exec_pkg::effects_t'{pcLoad:1'h1, pcValue:12'hFFF, default:'0}, 2'h2};
        rows[2] = '{mk(branch_exec_pkg::FAR_CALL_OP, 12'h5A5, 7'h0, 1'h0, 8'h0, 12'hFFF, 8'h0,
            8'h0), branch_exec_pkg::effects_t'{pcLoad:1'h1, pcValue:12'h5A5, stackPush:1'h1,
            default:'0}, 2'h2};
        rows[3] = '{mk(branch_exec_pkg::COMPUTED_BRANCH_OP, 12'h0, 7'h0, 1'h0, 8'h0, 12'h800,
            8'h34, 8'hFD), branch_exec_pkg::effects_t'{pcLoad:1'h1, pcValue:12'hD34,
            default:'0}, 2'h2};
        rows[4] = '{mk(branch_exec_pkg::INCREMENT_OP, 12'h0, 7'h7F, 1'h1, 8'hFF, 12'h0, 8'h0,
            8'h0), branch_exec_pkg::effects_t'{regWe:1'h1, regAddr:7'h7F, zeroWe:1'h1,
            zeroValue:1'h1, done:1'h1, default:'0}, 2'h1};
        rows[5] = '{mk(branch_exec_pkg::INCREMENT_OP, 12'h0, 7'h00, 1'h0, 8'h41, 12'h0, 8'h0,
            8'h0), branch_exec_pkg::effects_t'{accumulatorWe:1'h1, accumulatorValue:8'h42,
            zeroWe:1'h1, regValue:8'h42, done:1'h1, default:'0}, 2'h1};
        rows[6] = '{mk(branch_exec_pkg::SOFT_IRQ_OP, 12'h0, 7'h0, 1'h0, 8'h0, 12'hA10, 8'h0,
            8'h0), branch_exec_pkg::effects_t'{stackPush:1'h1, stackValue:12'hA11,
            default:'0}, 2'h3};
        rows[7] = '{mk(branch_exec_pkg::op_t'(3'h6), 12'h123, 7'h0, 1'h0, 8'h0, 12'h0, 8'h0,
            8'h0), branch_exec_pkg::effects_t'{done:1'h1, default:'0}, 2'h1};
        repeat (3) @(posedge clk);
        #1;
        reset_n = 1'h1;
        check({reqReady, globalIrqEnable, fx}, {1'h1, 1'h0, 54'h0});
        foreach (rows[i]) begin
            run(rows[i]);
        end
        check(globalIrqEnable, 1'h1);
        // back-to-back increments, one per cycle
        @(posedge clk);
        #1;
        reqValid = 1'h1;
        req = rows[5].r;
        @(posedge clk);
        #1;
        req = rows[4].r;
        check(fx, rows[5].e);
        check(reqReady, 1'h1);
        @(posedge clk);
        #1;
        reqValid = 1'h0;
        check(fx, rows[4].e);
        // held request refused while busy, taken in the done cycle
        @(posedge clk);
        #1;
        reqValid = 1'h1;
        req = rows[1].r;
        @(posedge clk);
        #1;
        req = rows[5].r;
        check(fx, rows[1].e);
        @(posedge clk);
        #1;
        check(fx, rows[0].e);
        @(posedge clk);
        #1;
        reqValid = 1'h0;
        check(fx, rows[5].e);
        // reset in the middle of a far branch
        @(posedge clk);
        #1;
        reqValid = 1'h1;
        req = rows[1].r;
        @(posedge clk);
        #1;
        reqValid = 1'h0;
        reset_n = 1'h0;
        #1;
        check({reqReady, globalIrqEnable, fx}, {1'h1, 1'h0, 54'h0});
        @(posedge clk);
        #1;
        reset_n = 1'h1;
        run(rows[6]);
        check(globalIrqEnable, 1'h0);
        summarize();
    end
endmodule
